/* hw/epsl_decode_if.sv */
// Word-address decode carrier between the loader and its decoder
`timescale 1ns/1ps
interface epsl_decode_if;
    import epsl_pkg::*;
    logic [EE_AW-1:0] addr;
    logic [PORT_W-1:0] port;
    epsl_kind_t kind;
    modport dec (input addr, output port, output kind);
    modport user (output addr, input port, input kind);
endinterface

/* hw/epsl_loader.sv */
// Loads EEPROM words into per-port PM, slot and VC configuration fields
`timescale 1ns/1ps
module epsl_loader (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic eeWordValid,
    input wire logic [epsl_pkg::EE_AW-1:0] eeWordAddr,
    input wire logic [epsl_pkg::EE_DW-1:0] eeWordData,
    input wire logic eeLoadDone,
    input wire logic cfgReq,
    input wire logic [epsl_pkg::PORT_W-1:0] cfgPort,
    input wire logic [epsl_pkg::CFG_AW-1:0] cfgOffset,
    output logic cfgAck,
    output logic [epsl_pkg::CFG_DW-1:0] cfgData,
    output logic loadDone
);
    import epsl_pkg::*;

    epsl_state_s_t cur;
    epsl_state_s_t next_cur;

    epsl_decode_if decIf();

    epsl_word_decode u_decode (
        .dif(decIf.dec)
    );

    assign decIf.addr = eeWordAddr;

    // Capability dword; D1 and D2 support are offered whatever the word held
    function automatic logic [CFG_DW-1:0] pmCapImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_AUX_LO +: W_AUX] = s.auxCurrent[p];
        w[CFG_D1] = 1'b1;
        w[CFG_D2] = 1'b1;
        w[CFG_PME_LO +: W_PME] = s.pmeD2D1[p];
        w[CFG_DSI] = s.devInit[p];
        pmCapImage = w;
    endfunction

    // Control/data dword; power-state control bits live elsewhere and read zero
    function automatic logic [CFG_DW-1:0] pmCsrImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_NSR] = s.noSoftReset[p];
        w[CFG_PMDATA_LO +: W_PMDATA] = s.pmData[p];
        pmCsrImage = w;
    endfunction

    // Express capability dword; only the slot flag is ours
    function automatic logic [CFG_DW-1:0] expCapImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_SLOTIMPL] = s.slotImpl[p];
        expCapImage = w;
    endfunction

    // Link capability dword; logical port number only
    function automatic logic [CFG_DW-1:0] linkCapImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_LPORT_LO +: W_LPORT] = s.logicalPort[p];
        linkCapImage = w;
    endfunction

    // Link control/status dword; slot clock choice only
    function automatic logic [CFG_DW-1:0] linkCtlImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_SLOTCLK] = s.slotClock[p];
        linkCtlImage = w;
    endfunction

    // Port VC capability dword; low-priority VC count only
    function automatic logic [CFG_DW-1:0] vcCap1Image(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_LPVC] = s.lowPrioVc[p];
        vcCap1Image = w;
    endfunction

    // VC0 resource control dword; TC0 always travels on VC0
    function automatic logic [CFG_DW-1:0] vc0CtlImage(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        w[CFG_TC0] = 1'b1;
        w[CFG_TCMAP_LO +: W_TCMAP] = s.tcMap[p];
        vc0CtlImage = w;
    endfunction

    // Assemble one register image for a port; unmapped offsets read zero
    function automatic logic [CFG_DW-1:0] readWord(
        input epsl_state_s_t s,
        input logic [PORT_W-1:0] p,
        input logic [CFG_AW-1:0] ofs
    );
        logic [CFG_DW-1:0] w;
        w = '0;
        if (p < PORT_W'(NPORT)) begin
            if (ofs == OFS_PM_CAP) begin
                w = pmCapImage(s, p);
            end else if (ofs == OFS_PM_CSR) begin
                w = pmCsrImage(s, p);
            end else if (ofs == OFS_EXP_CAP) begin
                w = expCapImage(s, p);
            end else if (ofs == OFS_LINK_CAP) begin
                w = linkCapImage(s, p);
            end else if (ofs == OFS_LINK_CTL) begin
                w = linkCtlImage(s, p);
            end else if (ofs == OFS_VC_CAP1) begin
                w = vcCap1Image(s, p);
            end else if (ofs == OFS_VC0_CTL) begin
                w = vc0CtlImage(s, p);
            end
        end
        readWord = w;
    endfunction

    // Load phase stores fields, ready phase answers reads
    always_comb begin
        next_cur = cur;
        next_cur.ack = 1'b0;
        case (cur.state)
            ST_LOAD: begin
                // Words after the done strobe are dropped; the image is frozen
                if (eeWordValid) begin
                    case (decIf.kind)
                        K_PM_LO: begin
                            next_cur.noSoftReset[decIf.port] = eeWordData[EE_NSR];
                            next_cur.auxCurrent[decIf.port] =
                                eeWordData[EE_AUX_LO +: W_AUX];
                            next_cur.pmeD2D1[decIf.port] =
                                eeWordData[EE_PME_LO +: W_PME];
                        end
                        K_PM_HI: begin
                            next_cur.pmData[decIf.port] =
                                eeWordData[EE_PMDATA_LO +: W_PMDATA];
                        end
                        K_SLOT: begin
                            // Port 0 has no slot, so its bit 0 is ignored
                            if (decIf.port != '0) begin
                                next_cur.slotImpl[decIf.port] =
                                    eeWordData[EE_SLOTIMPL];
                            end
                            next_cur.slotClock[decIf.port] =
                                eeWordData[EE_SLOTCLK];
                            next_cur.devInit[decIf.port] = eeWordData[EE_DSI];
                            next_cur.lowPrioVc[decIf.port] = eeWordData[EE_LPVC];
                            next_cur.logicalPort[decIf.port] =
                                eeWordData[EE_LPORT_LO +: W_LPORT];
                            next_cur.tcMap[decIf.port] =
                                eeWordData[EE_TCMAP_LO +: W_TCMAP];
                        end
                        default: begin
                        end
                    endcase
                end
                if (eeLoadDone) begin
                    next_cur.state = ST_READY;
                    next_cur.loaded = 1'b1;
                end
            end
            ST_READY: begin
                // Requests wait in LOAD, so software never sees half a load
                if (cfgReq && !cur.ack) begin
                    next_cur.ack = 1'b1;
                    next_cur.data = readWord(cur, cfgPort, cfgOffset);
                end
            end
            default: begin
                next_cur.state = ST_LOAD;
            end
        endcase
    end

    // Reset image: every loaded field clear, load phase, no answer pending
    function automatic epsl_state_s_t resetImage();
        epsl_state_s_t r;
        r = '0;
        r.state = ST_LOAD;
        resetImage = r;
    endfunction

    // Single state register; a reset forgets the load, so reads wait for a new one
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cur <= resetImage();
        end else begin
            cur <= next_cur;
        end
    end

    assign cfgAck = cur.ack;
    assign cfgData = cur.data;
    assign loadDone = cur.loaded;
endmodule

/* hw/epsl_pkg.sv */
// Constants and types for the EEPROM power-management and slot field loader
package epsl_pkg;
    localparam int NPORT = 6;
    localparam int EE_AW = 8;
    localparam int EE_DW = 16;
    localparam int CFG_AW = 12;
    localparam int CFG_DW = 32;
    localparam int PORT_W = 3;

    // EEPROM word addresses: base for port 0, two words per port
    localparam logic [EE_AW-1:0] EE_PM_BASE = 8'h50;
    localparam logic [EE_AW-1:0] EE_SLOT_BASE = 8'h60;
    localparam logic [EE_AW-1:0] EE_SPAN = 8'h0c;

    // Configuration offsets
    localparam logic [CFG_AW-1:0] OFS_PM_CAP = 12'h040;
    localparam logic [CFG_AW-1:0] OFS_PM_CSR = 12'h044;
    localparam logic [CFG_AW-1:0] OFS_EXP_CAP = 12'h0c0;
    localparam logic [CFG_AW-1:0] OFS_LINK_CAP = 12'h0cc;
    localparam logic [CFG_AW-1:0] OFS_LINK_CTL = 12'h0d0;
    localparam logic [CFG_AW-1:0] OFS_VC_CAP1 = 12'h144;
    localparam logic [CFG_AW-1:0] OFS_VC0_CTL = 12'h154;

    // Field widths
    localparam int W_AUX = 3;
    localparam int W_PME = 2;
    localparam int W_PMDATA = 8;
    localparam int W_LPORT = 3;
    localparam int W_TCMAP = 7;

    // Bit positions inside the EEPROM words
    localparam int EE_NSR = 0;
    localparam int EE_AUX_LO = 1;
    localparam int EE_PME_LO = 6;
    localparam int EE_PMDATA_LO = 8;
    localparam int EE_SLOTIMPL = 0;
    localparam int EE_SLOTCLK = 1;
    localparam int EE_DSI = 2;
    localparam int EE_LPVC = 3;
    localparam int EE_LPORT_LO = 4;
    localparam int EE_TCMAP_LO = 9;

    // Bit positions inside the configuration registers
    localparam int CFG_NSR = 3;
    localparam int CFG_DSI = 21;
    localparam int CFG_AUX_LO = 22;
    localparam int CFG_D1 = 25;
    localparam int CFG_D2 = 26;
    localparam int CFG_PME_LO = 28;
    localparam int CFG_PMDATA_LO = 24;
    localparam int CFG_SLOTIMPL = 24;
    localparam int CFG_LPORT_LO = 24;
    localparam int CFG_SLOTCLK = 28;
    localparam int CFG_LPVC = 4;
    localparam int CFG_TC0 = 0;
    localparam int CFG_TCMAP_LO = 1;

    typedef enum logic [3:0] {
        K_NONE = 4'h1,
        K_PM_LO = 4'h2,
        K_PM_HI = 4'h4,
        K_SLOT = 4'h8
    } epsl_kind_t;

    typedef enum logic [1:0] {
        ST_LOAD = 2'h1,
        ST_READY = 2'h2
    } epsl_state_t;

    typedef struct packed {
        epsl_state_t state;
        logic loaded;
        logic ack;
        logic [CFG_DW-1:0] data;
        logic [NPORT-1:0] noSoftReset;
        logic [NPORT-1:0][W_AUX-1:0] auxCurrent;
        logic [NPORT-1:0][W_PME-1:0] pmeD2D1;
        logic [NPORT-1:0][W_PMDATA-1:0] pmData;
        logic [NPORT-1:0] slotImpl;
        logic [NPORT-1:0] slotClock;
        logic [NPORT-1:0] devInit;
        logic [NPORT-1:0] lowPrioVc;
        logic [NPORT-1:0][W_LPORT-1:0] logicalPort;
        logic [NPORT-1:0][W_TCMAP-1:0] tcMap;
    } epsl_state_s_t;
endpackage

/* hw/epsl_word_decode.sv */
// Maps an EEPROM word address onto a port index and a word kind
`timescale 1ns/1ps
module epsl_word_decode (
    epsl_decode_if.dec dif
);
    import epsl_pkg::*;

    // Offset from a base, or K_NONE when outside the per-port window
    function automatic logic [PORT_W+1:0] classify(input logic [EE_AW-1:0] a);
        logic [EE_AW-1:0] offPm;
        logic [EE_AW-1:0] offSlot;
        offPm = a - EE_PM_BASE;
        offSlot = a - EE_SLOT_BASE;
        if (a >= EE_PM_BASE && offPm < EE_SPAN) begin
            classify = {offPm[0] ? 2'h2 : 2'h1, offPm[PORT_W:1]};
        end else if (a >= EE_SLOT_BASE && offSlot < EE_SPAN && !offSlot[0]) begin
            classify = {2'h3, offSlot[PORT_W:1]};
        end else begin
            classify = '0;
        end
    endfunction

    logic [PORT_W+1:0] cls;

    // Odd slot-range words carry nothing for this block
    always_comb begin
        cls = classify(dif.addr);
        dif.port = cls[PORT_W-1:0];
        case (cls[PORT_W+1:PORT_W])
            2'h1: dif.kind = K_PM_LO;
            2'h2: dif.kind = K_PM_HI;
            2'h3: dif.kind = K_SLOT;
            default: dif.kind = K_NONE;
        endcase
    end
endmodule

/* test/epsl_ee_model.sv */
// Behavioural EEPROM side: hands preload words and the end-of-load strobe over
`timescale 1ns/1ps
module epsl_ee_model (
    input wire logic clk,
    output logic eeWordValid,
    output logic [epsl_pkg::EE_AW-1:0] eeWordAddr,
    output logic [epsl_pkg::EE_DW-1:0] eeWordData,
    output logic eeLoadDone
);
    import epsl_pkg::*;
    // Idle bus shows no word
    initial begin
        eeWordValid = 1'h0;
        eeWordAddr = 8'hff;
        eeWordData = 16'h0;
        eeLoadDone = 1'h0;
    end
    // Stale bus is inverted so nothing can live on a leftover value
    task automatic put(input logic [EE_AW-1:0] a, input logic [EE_DW-1:0] d);
        @(posedge clk);
        #1;
        eeWordValid = 1'h1;
        eeWordAddr = a;
        eeWordData = d;
        @(posedge clk);
        #1;
        eeWordValid = 1'h0;
        eeWordAddr = ~a;
        eeWordData = ~d;
    endtask
    task automatic done();
        @(posedge clk);
        #1;
        eeLoadDone = 1'h1;
        @(posedge clk);
        #1;
        eeLoadDone = 1'h0;
    endtask
endmodule

/* test/epsl_loader_assertions.sv */
// Concurrent checks on the loader's read handshake and forced bits
`timescale 1ns/1ps
module epsl_loader_assertions (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic eeLoadDone,
    input wire logic cfgReq,
    input wire logic [epsl_pkg::PORT_W-1:0] cfgPort,
    input wire logic [epsl_pkg::CFG_AW-1:0] cfgOffset,
    input wire logic cfgAck,
    input wire logic [epsl_pkg::CFG_DW-1:0] cfgData,
    input wire logic loadDone
);
    import epsl_pkg::*;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // One answer, exactly one cycle after a taken request
    AST_ACK_NEXT: assert property (cfgReq && loadDone && !cfgAck |=> cfgAck)
        else $error("read not answered");
    AST_ACK_CAUSE: assert property (cfgAck |-> $past(cfgReq) && $past(loadDone))
        else $error("answer without loaded request");
    AST_ACK_PULSE: assert property (cfgAck |=> !cfgAck)
        else $error("answer too long");
    // Past reset gate: a one-cycle reset clears data without an answer
    AST_DATA_HOLD: assert property ($past(rst_b) && !cfgAck |-> $stable(cfgData))
        else $error("read data moved");
    // Load completion is sticky and caused by the end-of-load strobe
    AST_DONE_STAY: assert property (loadDone |=> loadDone)
        else $error("load done dropped");
    AST_DONE_CAUSE: assert property ($rose(loadDone) |-> $past(eeLoadDone))
        else $error("load done without strobe");
    // Forced-one bits, whatever the EEPROM held
    AST_D1_D2_ONE: assert property (
        cfgAck && $past(cfgOffset) == OFS_PM_CAP && $past(cfgPort) < 3'h6
        |-> cfgData[CFG_D2:CFG_D1] == 2'h3) else $error("power state support bits clear");
    AST_TC0_ONE: assert property (
        cfgAck && $past(cfgOffset) == OFS_VC0_CTL && $past(cfgPort) < 3'h6
        |-> cfgData[CFG_TC0]) else $error("class zero map bit clear");
endmodule
bind epsl_loader epsl_loader_assertions chk_u (.clk, .rst_b, .eeLoadDone, .cfgReq, .cfgPort,
    .cfgOffset, .cfgAck, .cfgData, .loadDone);

/* test/tb.sv */
// Self-checking bench for the EEPROM power-management and slot loader
`timescale 1ns/1ps
module tb;
    import epsl_pkg::*;
    logic clk = 1'h0;
    logic rst_b = 1'h0;
    logic eeWordValid, eeLoadDone, cfgAck, loadDone;
    logic cfgReq = 1'h0;
    logic [EE_AW-1:0] eeWordAddr;
    logic [EE_DW-1:0] eeWordData;
    logic [PORT_W-1:0] cfgPort = 3'h0;
    logic [CFG_AW-1:0] cfgOffset = 12'h0;
    logic [CFG_DW-1:0] cfgData, seen;
    logic [EE_DW-1:0] pmw [NPORT], dw [NPORT], sw [NPORT];
    logic [CFG_AW-1:0] ofs [8] = '{OFS_PM_CAP, OFS_PM_CSR, OFS_EXP_CAP, OFS_LINK_CAP,
        OFS_LINK_CTL, OFS_VC_CAP1, OFS_VC0_CTL, 12'h048};
    int fail_count = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    epsl_ee_model ee_u (.clk(clk), .eeWordValid(eeWordValid), .eeWordAddr(eeWordAddr),
        .eeWordData(eeWordData), .eeLoadDone(eeLoadDone));
    epsl_loader dut_u (.clk(clk), .rst_b(rst_b), .eeWordValid(eeWordValid),
        .eeWordAddr(eeWordAddr), .eeWordData(eeWordData), .eeLoadDone(eeLoadDone),
        .cfgReq(cfgReq), .cfgPort(cfgPort), .cfgOffset(cfgOffset), .cfgAck(cfgAck),
        .cfgData(cfgData), .loadDone(loadDone));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [CFG_DW-1:0] got, input logic [CFG_DW-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Reads never wait forever: a missing answer ends the run
    task automatic rd(input logic [PORT_W-1:0] p, input logic [CFG_AW-1:0] o);
        @(posedge clk);
        #1;
        cfgReq = 1'h1;
        cfgPort = p;
        cfgOffset = o;
        for (int i = 0; i < 8 && cfgAck !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        if (cfgAck !== 1'h1) begin
            fail_count++;
            tally_and_finish();
        end
        seen = cfgData;
        cfgReq = 1'h0;
    endtask
    // Expected dword from the stored words; port 0 has no slot flag
    function automatic logic [CFG_DW-1:0] expv(input int p, input logic [CFG_AW-1:0] o);
        if (p > 5) return '0;
        case (o)
            OFS_PM_CAP: return {2'h0, pmw[p][7:6], 3'h3, pmw[p][3:1], sw[p][2], 21'h0};
            OFS_PM_CSR: return {dw[p][15:8], 20'h0, pmw[p][0], 3'h0};
            OFS_EXP_CAP: return {7'h0, sw[p][0] & (p != 0), 24'h0};
            OFS_LINK_CAP: return {5'h0, sw[p][6:4], 24'h0};
            OFS_LINK_CTL: return {3'h0, sw[p][1], 28'h0};
            OFS_VC_CAP1: return {27'h0, sw[p][3], 4'h0};
            OFS_VC0_CTL: return {24'h0, sw[p][15:9], 1'h1};
            default: return '0;
        endcase
    endfunction
    // Requests before the load completes get no answer
    task automatic t_early();
        @(posedge clk);
        #1;
        cfgReq = 1'h1;
        cfgOffset = OFS_PM_CSR;
        repeat (6) begin
            @(posedge clk);
            #1;
            check(cfgAck, 1'h0);
        end
        cfgReq = 1'h0;
    endtask
    // Overwrite, ignored odd slot word, then a word after load that must not land
    task automatic t_load();
        ee_u.put(EE_PM_BASE + 8'h2, ~pmw[1]);
        for (int p = 0; p < NPORT; p++) begin
            ee_u.put(EE_PM_BASE + 8'(2 * p), pmw[p]);
            ee_u.put(EE_PM_BASE + 8'(2 * p + 1), dw[p]);
            ee_u.put(EE_SLOT_BASE + 8'(2 * p), sw[p]);
        end
        ee_u.put(EE_SLOT_BASE + 8'h1, 16'h0);
        ee_u.done();
        for (int i = 0; i < 8 && loadDone !== 1'h1; i++) begin
            @(posedge clk);
            #1;
        end
        check(loadDone, 1'h1);
        if (loadDone !== 1'h1) begin
            tally_and_finish();
        end
        ee_u.put(EE_PM_BASE, ~pmw[0]);
    endtask
    task automatic t_read();
        for (int p = 0; p < 7; p++) begin
            for (int k = 0; k < 8; k++) begin
                rd(3'(p), ofs[k]);
                check(seen, expv(p, ofs[k]));
            end
        end
    endtask
    // Mid-run reset: image and done flag clear; after a bare done strobe, reads see only the forced bits
    task automatic t_reset();
        @(posedge clk);
        #1;
        rst_b = 1'h0;
        repeat (2) @(posedge clk);
        #1;
        rst_b = 1'h1;
        check(loadDone, 1'h0);
        check(cfgAck, 1'h0);
        check(cfgData, 32'h0);
        ee_u.done();
        check(loadDone, 1'h1);
        rd(3'h1, OFS_PM_CAP);
        check(seen, (32'h1 << CFG_D1) | (32'h1 << CFG_D2));
        rd(3'h2, OFS_VC0_CTL);
        check(seen, 32'h1);
    endtask
    // Word patterns: power-state bits 4,5 clear so forcing shows; port 0 slot bit set
    initial begin
        for (int p = 0; p < NPORT; p++) begin
            pmw[p] = 16'((p * 16'h0047) ^ 16'h4389) & 16'hffcf;
            dw[p] = 16'(p * 16'h2953 + 16'h5a3c);
            sw[p] = 16'(16'hffff ^ (p * 16'h1357));
        end
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'h1;
        t_early();
        t_load();
        t_read();
        t_reset();
        tally_and_finish();
    end
endmodule
